/* File: design/wpd_pkg.sv */
// shared constants and carrier types for the wake pattern list decoder
package wpd_pkg;
  // pattern list memory geometry
  localparam int         WPD_AW        = 8;
  localparam int         WPD_DEPTH     = 256;
  // entry layout: skip count in the upper nibble, include count in the lower
  localparam int         WPD_SKIP_LSB  = 4;
  localparam int         WPD_INC_LSB   = 0;
  localparam logic [3:0] WPD_NIB_ESC   = 4'hF;
  localparam logic [7:0] WPD_TERM      = 8'h00;
  // reference crc is four bytes, least significant first
  localparam logic [1:0] WPD_CRC_LAST  = 2'h3;
  localparam logic [31:0] WPD_CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] WPD_CRC_POLY = 32'hEDB88320;

  typedef enum logic [2:0] {
    WPD_ST_IDLE = 3'b000,
    WPD_ST_RD   = 3'b001,
    WPD_ST_EVAL = 3'b010,
    WPD_ST_RUN  = 3'b011,
    WPD_ST_CMP  = 3'b100,
    WPD_ST_DONE = 3'b101
  } wpd_state_t;

  typedef enum logic [1:0] {
    WPD_SG_ENTRY = 2'b00,
    WPD_SG_XSKIP = 2'b01,
    WPD_SG_XINC  = 2'b10,
    WPD_SG_CRC   = 2'b11
  } wpd_stage_t;

  // receive byte stream from the mac, same clock
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } wpd_rx_t;

  // host load port into the pattern list memory
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } wpd_load_t;
endpackage

/* File: design/wpd_pattern_mem.sv */
// byte-wide pattern list memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module wpd_pattern_mem
  import wpd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              we,
  input  wire logic [WPD_AW-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic              re,
  input  wire logic [WPD_AW-1:0] raddr,
  output logic      [7:0]        rdata_r
);
  logic [7:0] mem_r [WPD_DEPTH];

  // no reset on the array; contents are whatever the host loaded
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
    if (re)
    begin
      rdata_r <= mem_r[raddr];
    end
  end
endmodule
`default_nettype wire

/* File: design/wpd_decoder.sv */
// wake pattern list decoder: walks a pattern list against a received frame
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - low nibble of an entry is the include count, plain values zero to 0xe
// - high nibble of an entry is the skip count, plain values zero to 0xe
// - a nibble of 0xf is an escape; its value comes from elsewhere
// - one escaped nibble takes its 8-bit value from the next entry
// - both escaped: next entry is skip, the one after is include
// - an entry of zero ends the pattern list
// - four reference crc bytes follow the terminator; next entry follows them
// - skip skip-count received bytes before selecting any
// - then feed include-count received bytes into the crc
// - ieee 802.3 crc over selected bytes; equal to reference raises wake
module wpd_decoder
  import wpd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire wpd_pkg::wpd_load_t load,
  input  wire logic [7:0]        list_base,
  input  wire wpd_pkg::wpd_rx_t  rx,
  output logic                   wake_event_r,
  output logic                   busy_r,
  output logic [7:0]             next_base_r
);
  import wpd_pkg::*;

  wpd_state_t  state_r, state_nxt;
  wpd_stage_t  stage_r, stage_nxt;
  logic [7:0]  rd_ptr_r, rd_ptr_nxt;
  logic [7:0]  skip_r, skip_nxt;
  logic [7:0]  inc_r, inc_nxt;
  logic        xinc_pend_r, xinc_pend_nxt;
  logic        ended_r, ended_nxt;
  logic [1:0]  idx_r, idx_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [31:0] ref_r, ref_nxt;
  logic        wake_nxt;
  logic        busy_nxt;
  logic [7:0]  next_base_nxt;
  logic        mem_re;
  logic [7:0]  rd_data;

  // escape test, shared by both nibbles
  function automatic logic is_esc(input logic [3:0] nib);
    return nib == WPD_NIB_ESC;
  endfunction

  // reflected crc-32 update, lsb of each byte first as on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ WPD_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wpd_pattern_mem u_mem (
    .mclk    (mclk),
    .we      (load.we),
    .waddr   (load.addr),
    .wdata   (load.data),
    .re      (mem_re),
    .raddr   (rd_ptr_r),
    .rdata_r (rd_data)
  );

  // next-state logic for the list walker
  always_comb
  begin
    state_nxt     = state_r;
    stage_nxt     = stage_r;
    rd_ptr_nxt    = rd_ptr_r;
    skip_nxt      = skip_r;
    inc_nxt       = inc_r;
    xinc_pend_nxt = xinc_pend_r;
    ended_nxt     = ended_r;
    idx_nxt       = idx_r;
    crc_nxt       = crc_r;
    ref_nxt       = ref_r;
    next_base_nxt = next_base_r;
    wake_nxt      = 1'b0;
    mem_re        = 1'b0;
    if (rx.sof)
    begin
      // a new frame restarts the walk, even mid-list
      state_nxt  = WPD_ST_RD;
      stage_nxt  = WPD_SG_ENTRY;
      rd_ptr_nxt = list_base;
      crc_nxt    = WPD_CRC_INIT;
      ended_nxt  = 1'b0;
    end
    else
    begin
      // frame end is remembered so trailing decode can still finish
      if (rx.eof && state_r != WPD_ST_IDLE)
      begin
        ended_nxt = 1'b1;
      end
      case (state_r)
        WPD_ST_IDLE: ;
        WPD_ST_RD:
        begin
          mem_re     = 1'b1;
          rd_ptr_nxt = rd_ptr_r + 8'h01;
          state_nxt  = WPD_ST_EVAL;
        end
        WPD_ST_EVAL:
        begin
          case (stage_r)
            WPD_SG_ENTRY:
            begin
              if (rd_data == WPD_TERM)
              begin
                stage_nxt = WPD_SG_CRC;
                idx_nxt   = 2'h0;
                state_nxt = WPD_ST_RD;
              end
              else
              begin
                skip_nxt      = {4'h0, rd_data[WPD_SKIP_LSB +: 4]};
                inc_nxt       = {4'h0, rd_data[WPD_INC_LSB +: 4]};
                xinc_pend_nxt = is_esc(rd_data[WPD_INC_LSB +: 4]);
                if (is_esc(rd_data[WPD_SKIP_LSB +: 4]))
                begin
                  stage_nxt = WPD_SG_XSKIP;
                  state_nxt = WPD_ST_RD;
                end
                else if (is_esc(rd_data[WPD_INC_LSB +: 4]))
                begin
                  stage_nxt = WPD_SG_XINC;
                  state_nxt = WPD_ST_RD;
                end
                else
                begin
                  state_nxt = WPD_ST_RUN;
                end
              end
            end
            WPD_SG_XSKIP:
            begin
              skip_nxt = rd_data;
              if (xinc_pend_r)
              begin
                stage_nxt = WPD_SG_XINC;
                state_nxt = WPD_ST_RD;
              end
              else
              begin
                state_nxt = WPD_ST_RUN;
              end
            end
            WPD_SG_XINC:
            begin
              inc_nxt   = rd_data;
              state_nxt = WPD_ST_RUN;
            end
            WPD_SG_CRC:
            begin
              ref_nxt[8*idx_r +: 8] = rd_data;
              if (idx_r == WPD_CRC_LAST)
              begin
                state_nxt = WPD_ST_CMP;
              end
              else
              begin
                idx_nxt   = idx_r + 2'h1;
                state_nxt = WPD_ST_RD;
              end
            end
            default: state_nxt = WPD_ST_IDLE;
          endcase
        end
        WPD_ST_RUN:
        begin
          if (skip_r == 8'h00 && inc_r == 8'h00)
          begin
            stage_nxt = WPD_SG_ENTRY;
            state_nxt = WPD_ST_RD;
          end
          else if (ended_r)
          begin
            // frame too short for the pattern: no wake
            state_nxt = WPD_ST_IDLE;
          end
          else if (rx.valid)
          begin
            if (skip_r != 8'h00)
            begin
              skip_nxt = skip_r - 8'h01;
            end
            else
            begin
              crc_nxt = crc_byte(crc_r, rx.data);
              inc_nxt = inc_r - 8'h01;
            end
          end
        end
        WPD_ST_CMP:
        begin
          wake_nxt      = (~crc_r == ref_r);
          next_base_nxt = rd_ptr_r;
          state_nxt     = WPD_ST_DONE;
        end
        WPD_ST_DONE:
        begin
          if (ended_r || rx.eof)
          begin
            state_nxt = WPD_ST_IDLE;
          end
        end
        default: state_nxt = WPD_ST_IDLE;
      endcase
    end
    busy_nxt = (state_nxt != WPD_ST_IDLE);
  end

  // state and output registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r      <= WPD_ST_IDLE;
      stage_r      <= WPD_SG_ENTRY;
      rd_ptr_r     <= 8'h00;
      skip_r       <= 8'h00;
      inc_r        <= 8'h00;
      xinc_pend_r  <= 1'b0;
      ended_r      <= 1'b0;
      idx_r        <= 2'h0;
      crc_r        <= WPD_CRC_INIT;
      ref_r        <= 32'h00000000;
      wake_event_r <= 1'b0;
      busy_r       <= 1'b0;
      next_base_r  <= 8'h00;
    end
    else
    begin
      state_r      <= state_nxt;
      stage_r      <= stage_nxt;
      rd_ptr_r     <= rd_ptr_nxt;
      skip_r       <= skip_nxt;
      inc_r        <= inc_nxt;
      xinc_pend_r  <= xinc_pend_nxt;
      ended_r      <= ended_nxt;
      idx_r        <= idx_nxt;
      crc_r        <= crc_nxt;
      ref_r        <= ref_nxt;
      wake_event_r <= wake_nxt;
      busy_r       <= busy_nxt;
      next_base_r  <= next_base_nxt;
    end
  end

  // checks on the walker
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic ev_entry;
  assign ev_entry = state_r == WPD_ST_EVAL && stage_r == WPD_SG_ENTRY && !rx.sof;

  AST_INC_NIBBLE: assert property (ev_entry && rd_data != WPD_TERM
    |=> inc_r == {4'h0, $past(rd_data[3:0])}) else $error("include nibble lost");
  AST_SKIP_NIBBLE: assert property (ev_entry && rd_data != WPD_TERM
    |=> skip_r == {4'h0, $past(rd_data[7:4])}) else $error("skip nibble lost");
  AST_SKIP_ESCAPE: assert property (ev_entry && rd_data[7:4] == WPD_NIB_ESC
    |=> stage_r == WPD_SG_XSKIP ##1 state_r == WPD_ST_EVAL) else $error("escape missed");
  AST_ONE_ESC_EXT: assert property (ev_entry && rd_data[7:4] != WPD_NIB_ESC
    && rd_data[3:0] == WPD_NIB_ESC ##1 !rx.sof ##1 !rx.sof
    |=> inc_r == $past(rd_data)) else $error("extended include wrong");
  AST_BOTH_ESC: assert property (ev_entry && rd_data == 8'hFF
    |=> stage_r == WPD_SG_XSKIP && xinc_pend_r) else $error("double escape order");
  AST_TERMINATOR: assert property (ev_entry && rd_data == WPD_TERM
    |=> stage_r == WPD_SG_CRC && state_r == WPD_ST_RD) else $error("terminator missed");
  AST_NEXT_BASE: assert property (state_r == WPD_ST_CMP
    |=> next_base_r == $past(rd_ptr_r)) else $error("next entry base wrong");
  AST_SKIP_FIRST: assert property (state_r == WPD_ST_RUN && rx.valid && skip_r != 8'h00
    && !ended_r && !rx.sof |=> $stable(crc_r) && inc_r == $past(inc_r))
    else $error("skipped byte fed crc");
  AST_INCLUDE: assert property (state_r == WPD_ST_RUN && rx.valid && skip_r == 8'h00
    && inc_r != 8'h00 && !ended_r && !rx.sof |=> inc_r == $past(inc_r) - 8'h01)
    else $error("include count not consumed");
  AST_WAKE_MATCH: assert property (state_r == WPD_ST_CMP && ~crc_r == ref_r
    |=> wake_event_r ##1 !wake_event_r) else $error("wake not one pulse");
  AST_NO_FALSE_WAKE: assert property (wake_event_r
    |-> $past(state_r) == WPD_ST_CMP) else $error("wake without compare");
  AST_EXT_SKIP: assert property (state_r == WPD_ST_EVAL && stage_r == WPD_SG_XSKIP && !rx.sof
    |=> skip_r == $past(rd_data)) else $error("extended skip wrong");

  COV_WAKE: cover property (wake_event_r);
  COV_BOTH_ESC: cover property (ev_entry && rd_data == 8'hFF);
  COV_SHORT_FRAME: cover property (state_r == WPD_ST_RUN && ended_r ##1 state_r == WPD_ST_IDLE);
endmodule
`default_nettype wire

/* File: tb/wpd_host_mac_model.sv */
// host loader and receive mac model driving the decoder's load and rx ports
`timescale 1ns/100ps
`default_nettype none
module wpd_host_mac_model
  import wpd_pkg::*;
(
  input  wire logic           mclk,
  output var  wpd_pkg::wpd_load_t load,
  output var  wpd_pkg::wpd_rx_t   rx
);
  // quiet start before the first request
  initial
  begin
    load = '0;
    rx   = '0;
  end

  // one cycle of idle lines; released data toggles so a stale byte never passes
  task automatic tick();
    @(posedge mclk);
    #1;
    load.we   = 1'b0;
    load.data = ~load.data;
    rx.valid  = 1'b0;
    rx.sof    = 1'b0;
    rx.eof    = 1'b0;
    rx.data   = ~rx.data;
  endtask

  // entries, terminator and reference crc go in as one contiguous run
  task automatic write_list(input logic [7:0] base, input logic [7:0] q[$]);
    foreach (q[i])
    begin
      tick();
      load.we   = 1'b1;
      load.addr = 8'(base + i);
      load.data = q[i];
    end
    tick();
  endtask

  // ten cycles between bytes: above the walker's minimum spacing of eight
  task automatic send_frame(input logic [7:0] q[$]);
    tick();
    rx.sof = 1'b1;
    foreach (q[i])
    begin
      repeat (10) tick();
      rx.valid = 1'b1;
      rx.data  = q[i];
    end
    repeat (10) tick();
    rx.eof = 1'b1;
    tick();
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the wake pattern list decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import wpd_pkg::*;
  logic       mclk;
  logic       rst;
  logic [7:0] list_base;
  wpd_load_t  load;
  wpd_rx_t    rx;
  logic       wake_event_r;
  logic       busy_r;
  logic [7:0] next_base_r;
  int         failures;
  int         tests_run;
  int         wakes;

  wpd_host_mac_model pm (.mclk(mclk), .load(load), .rx(rx));
  wpd_decoder DUT (.mclk(mclk), .rst(rst), .load(load), .list_base(list_base), .rx(rx),
    .wake_event_r(wake_event_r), .busy_r(busy_r), .next_base_r(next_base_r));

  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // counts wake pulses, which may land before or after eof
  always @(posedge mclk)
    if (wake_event_r === 1'b1)
      wakes <= wakes + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // reflected frame-check crc, result inverted
  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i])
    begin
      c = c ^ {24'h000000, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return ~c;
  endfunction

  // decodes the list itself, loads it with its crc, sends a frame, judges the outcome
  task automatic run_case(input logic [7:0] base, input logic [7:0] lst[$], input int flen,
                          input bit bad, input int exp_w, input bit chk_nb);
    logic [7:0]  fr[$];
    logic [7:0]  sel[$];
    logic [7:0]  img[$];
    logic [31:0] c;
    int          i;
    int          pos;
    int          s;
    int          n;
    for (i = 0; i < flen; i++)
      fr.push_back(8'(i * 37 + 5));
    i = 0;
    pos = 0;
    while (lst[i] !== 8'h00)
    begin
      s = lst[i][7:4];
      n = lst[i][3:0];
      if (s == 15)
        s = lst[++i];
      if (n == 15)
        n = lst[++i];
      i++;
      for (int k = 0; k < n; k++)
        if (pos + s + k < flen)
          sel.push_back(fr[pos + s + k]);
      pos = pos + s + n;
    end
    c = crc_of(sel) ^ {31'h0, bad};
    img = lst;
    for (i = 0; i < 4; i++)
      img.push_back(c[8*i +: 8]);
    pm.write_list(base, img);
    list_base = base;
    wakes = 0;
    pm.send_frame(fr);
    for (i = 0; i < 200 && busy_r !== 1'b0; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check("busy_r", {31'h0, busy_r}, 0);
    check("wake count", wakes, exp_w);
    if (chk_nb)
      check("next_base_r", {24'h0, next_base_r}, {24'h0, 8'(base + img.size())});
  endtask

  task automatic plain_match();
    run_case(8'h00, '{8'h21, 8'h00}, 6, 1'b0, 1, 1'b1);
  endtask

  task automatic wrong_crc();
    run_case(8'h00, '{8'h21, 8'h00}, 6, 1'b1, 0, 1'b1);
  endtask

  // one-nibble escapes, both escaped, then the largest plain skip
  task automatic escaped_counts();
    run_case(8'h20, '{8'hF3, 8'h10, 8'h1F, 8'h11, 8'hFF, 8'h05, 8'h03, 8'hE2, 8'h00},
             64, 1'b0, 1, 1'b1);
  endtask

  // list and crc run across the top of memory
  task automatic wrapped_list();
    run_case(8'hFC, '{8'h12, 8'h00}, 5, 1'b0, 1, 1'b1);
  endtask

  // frame ends before the included byte arrives
  task automatic short_frame();
    run_case(8'h00, '{8'h21, 8'h00}, 2, 1'b0, 0, 1'b0);
  endtask

  // about 20000 cycles, roughly twenty times the expected run
  initial
  begin
    #100000;
    failures++;
    results();
  end

  // reset, then the scenarios in turn
  initial
  begin
    failures = 0;
    tests_run = 0;
    wakes = 0;
    rst = 1'b1;
    list_base = 8'h00;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    check("busy_r", {31'h0, busy_r}, 0);
    check("wake_event_r", {31'h0, wake_event_r}, 0);
    check("next_base_r", {24'h0, next_base_r}, 0);
    plain_match();
    wrong_crc();
    escaped_counts();
    wrapped_list();
    short_frame();
    results();
  end
endmodule
`default_nettype wire
